// ===== rtl/pcs_top.sv
// Programmable clocks, clock status flags and clock interrupt with APB access
// What this block does
// - Four independent programmable clock registers, one per output clock.
// - Bits 1:0 pick source: slow, main, PLL A, PLL B.
// - Bits 4:2 pick divider 1,2,4..64; code 111 divides by 128.
// - Writing one to enable register enables that interrupt; zero does nothing.
// - Writing one to disable register disables that interrupt; zero does nothing.
// - Enable, disable, status, mask share layout: bits 0-3 and 8-11.
// - Oscillator stable bit reads one once oscillator has stabilised.
// - PLL A lock bit reads one while PLL A is locked.
// - PLL B lock bit reads one while PLL B is locked.
// - Master clock ready bit reads one when master clock is usable.
// - Each programmable clock ready bit reads one when its output is ready.
// - Mask register reads zero for enabled, one for disabled interrupts.
// - Oscillator stable rises only after programmed slow clock start-up count.
// - PLL A locks after programmed slow clock count following its write.
// - PLL B locks after programmed slow clock count following its write.
module pcs_top import pcs_pkg::*; (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] src_tick,
	output logic [NUM_PCK-1:0] prog_clk_tick,
	output logic irq
);
	// Bus slave state
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic [31:0] prdata_r, prdata_nxt;

	// Configuration state
	logic [CFG_W-1:0] pck_cfg_r [NUM_PCK];
	logic [CFG_W-1:0] pck_cfg_nxt [NUM_PCK];
	logic osc_en_r, osc_en_nxt;
	logic [OSC_CNT_W-1:0] osc_cnt_r, osc_cnt_nxt;
	logic [PLL_CNT_W-1:0] pll_a_cnt_r, pll_a_cnt_nxt;
	logic [PLL_CNT_W-1:0] pll_b_cnt_r, pll_b_cnt_nxt;
	logic [SRC_W-1:0] mck_src_r, mck_src_nxt;

	// Start-up and lock timers
	logic [OSC_CNT_W-1:0] osc_wait_r, osc_wait_nxt;
	logic main_osc_stable_r, main_osc_stable_nxt;
	logic [PLL_CNT_W-1:0] pll_a_wait_r, pll_a_wait_nxt;
	logic pll_a_arm_r, pll_a_arm_nxt;
	logic pll_a_locked_r, pll_a_locked_nxt;
	logic [PLL_CNT_W-1:0] pll_b_wait_r, pll_b_wait_nxt;
	logic pll_b_arm_r, pll_b_arm_nxt;
	logic pll_b_locked_r, pll_b_locked_nxt;
	logic master_clock_ready_r, master_clock_ready_nxt;

	// Interrupt state
	logic [STAT_W-1:0] irq_en_r, irq_en_nxt;
	logic [STAT_W-1:0] event_r, event_nxt;
	logic [STAT_W-1:0] status_q_r, status_q_nxt;
	logic irq_r, irq_nxt;

	logic [NUM_PCK-1:0] pck_load;
	logic [NUM_PCK-1:0] prog_clock_ready;
	logic [STAT_W-1:0] status_vec;
	logic wr_fire;
	logic rd_setup;
	logic slow_tick;
	// Write strobes of the control registers
	logic wr_osc_cfg;
	logic wr_pll_a_cfg;
	logic wr_pll_b_cfg;
	logic wr_mck_cfg;
	logic wr_irq_en;
	logic wr_irq_dis;
	logic wr_events;

	// Known word addresses; anything else answers with an error
	function automatic logic addr_known(input logic [ADDR_W-1:0] a);
		logic hit;
		hit = 1'b0;
		case (a)
			OFS_PCK0, OFS_PCK1, OFS_PCK2, OFS_PCK3, OFS_IRQ_ENABLE, OFS_IRQ_DISABLE,
			OFS_STATUS, OFS_IRQ_MASK, OFS_OSC_CFG, OFS_PLL_A_CFG, OFS_PLL_B_CFG,
			OFS_MCK_CFG, OFS_EVENTS: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		addr_known = hit;
	endfunction : addr_known

	// Move a 12-bit flag word into a bus word
	function automatic logic [31:0] flag_word(input logic [STAT_W-1:0] f);
		flag_word = {20'h0_0000, f & STAT_VALID};
	endfunction : flag_word

	// One step of a slow-clock down counter that ends in a lock flag
	function automatic logic [PLL_CNT_W-1:0] wait_step(input logic [PLL_CNT_W-1:0] w,
			input logic tick);
		wait_step = (tick && w != '0) ? w - 6'h01 : w;
	endfunction : wait_step

	assign slow_tick = src_tick[SRC_SLOW];
	// Write takes effect on the edge where the access phase sees pready
	assign wr_fire = psel && penable && pwrite && pready_r;
	assign rd_setup = psel && penable && !pready_r;
	assign wr_osc_cfg = wr_fire && paddr == OFS_OSC_CFG;
	assign wr_pll_a_cfg = wr_fire && paddr == OFS_PLL_A_CFG;
	assign wr_pll_b_cfg = wr_fire && paddr == OFS_PLL_B_CFG;
	assign wr_mck_cfg = wr_fire && paddr == OFS_MCK_CFG;
	assign wr_irq_en = wr_fire && paddr == OFS_IRQ_ENABLE;
	assign wr_irq_dis = wr_fire && paddr == OFS_IRQ_DISABLE;
	assign wr_events = wr_fire && paddr == OFS_EVENTS;

	always_comb begin
		for (int i = 0; i < NUM_PCK; i++) begin
			pck_load[i] = wr_fire && (paddr == OFS_PCK0 + ADDR_W'(4 * i));
		end
	end

	always_comb begin
		status_vec = '0;
		status_vec[BIT_OSC] = main_osc_stable_r;
		status_vec[BIT_PLL_A] = pll_a_locked_r;
		status_vec[BIT_PLL_B] = pll_b_locked_r;
		status_vec[BIT_MCK] = master_clock_ready_r;
		status_vec[BIT_PCK0 +: NUM_PCK] = prog_clock_ready;
	end

	// APB slave: one wait cycle, then answer with registered data
	always_comb begin
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		prdata_nxt = prdata_r;
		if (rd_setup) begin
			pready_nxt = 1'b1;
			pslverr_nxt = !addr_known(paddr);
			prdata_nxt = '0;
			if (!pwrite) begin
				case (paddr)
					OFS_PCK0: prdata_nxt = {27'h000_0000, pck_cfg_r[0]};
					OFS_PCK1: prdata_nxt = {27'h000_0000, pck_cfg_r[1]};
					OFS_PCK2: prdata_nxt = {27'h000_0000, pck_cfg_r[2]};
					OFS_PCK3: prdata_nxt = {27'h000_0000, pck_cfg_r[3]};
					OFS_STATUS: prdata_nxt = flag_word(status_vec);
					OFS_IRQ_MASK: prdata_nxt = flag_word(~irq_en_r);
					OFS_EVENTS: prdata_nxt = flag_word(event_r);
					OFS_OSC_CFG: begin
						prdata_nxt[OSC_EN_BIT] = osc_en_r;
						prdata_nxt[OSC_CNT_LSB +: OSC_CNT_W] = osc_cnt_r;
					end
					OFS_PLL_A_CFG: prdata_nxt[PLL_CNT_LSB +: PLL_CNT_W] = pll_a_cnt_r;
					OFS_PLL_B_CFG: prdata_nxt[PLL_CNT_LSB +: PLL_CNT_W] = pll_b_cnt_r;
					OFS_MCK_CFG: prdata_nxt[SRC_LSB +: SRC_W] = mck_src_r;
					default: prdata_nxt = '0;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// Configuration registers
	always_comb begin
		for (int i = 0; i < NUM_PCK; i++) begin
			pck_cfg_nxt[i] = pck_load[i] ? pwdata[CFG_W-1:0] : pck_cfg_r[i];
		end
		osc_en_nxt = osc_en_r;
		osc_cnt_nxt = osc_cnt_r;
		pll_a_cnt_nxt = pll_a_cnt_r;
		pll_b_cnt_nxt = pll_b_cnt_r;
		mck_src_nxt = mck_src_r;
		if (wr_fire) begin
			case (paddr)
				OFS_OSC_CFG: begin
					osc_en_nxt = pwdata[OSC_EN_BIT];
					osc_cnt_nxt = pwdata[OSC_CNT_LSB +: OSC_CNT_W];
				end
				OFS_PLL_A_CFG: pll_a_cnt_nxt = pwdata[PLL_CNT_LSB +: PLL_CNT_W];
				OFS_PLL_B_CFG: pll_b_cnt_nxt = pwdata[PLL_CNT_LSB +: PLL_CNT_W];
				OFS_MCK_CFG: mck_src_nxt = pwdata[SRC_LSB +: SRC_W];
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_PCK; i++) begin
				pck_cfg_r[i] <= RST_PCK_CFG;
			end
			osc_en_r <= 1'b0;
			osc_cnt_r <= RST_OSC_CNT;
			pll_a_cnt_r <= RST_PLL_CNT;
			pll_b_cnt_r <= RST_PLL_CNT;
			mck_src_r <= RST_MCK_SRC;
		end else begin
			pck_cfg_r <= pck_cfg_nxt;
			osc_en_r <= osc_en_nxt;
			osc_cnt_r <= osc_cnt_nxt;
			pll_a_cnt_r <= pll_a_cnt_nxt;
			pll_b_cnt_r <= pll_b_cnt_nxt;
			mck_src_r <= mck_src_nxt;
		end
	end

	// Start-up and lock timers counted in slow clock ticks, and the master clock ready flag
	always_comb begin
		osc_wait_nxt = osc_wait_r;
		main_osc_stable_nxt = main_osc_stable_r;
		pll_a_wait_nxt = pll_a_wait_r;
		pll_a_arm_nxt = pll_a_arm_r;
		pll_a_locked_nxt = pll_a_locked_r;
		pll_b_wait_nxt = pll_b_wait_r;
		pll_b_arm_nxt = pll_b_arm_r;
		pll_b_locked_nxt = pll_b_locked_r;
		master_clock_ready_nxt = master_clock_ready_r;

		if (wr_osc_cfg) begin
			// Any rewrite restarts the start-up time; disabling drops stability
			osc_wait_nxt = pwdata[OSC_CNT_LSB +: OSC_CNT_W];
			main_osc_stable_nxt = 1'b0;
		end else if (osc_en_r && !main_osc_stable_r) begin
			if (osc_wait_r == '0) begin
				main_osc_stable_nxt = 1'b1;
			end else if (slow_tick) begin
				osc_wait_nxt = osc_wait_r - 8'h01;
			end
		end

		if (wr_pll_a_cfg) begin
			pll_a_wait_nxt = pwdata[PLL_CNT_LSB +: PLL_CNT_W];
			pll_a_arm_nxt = 1'b1;
			pll_a_locked_nxt = 1'b0;
		end else if (pll_a_arm_r) begin
			pll_a_wait_nxt = wait_step(pll_a_wait_r, slow_tick);
			if (pll_a_wait_r == '0) begin
				pll_a_locked_nxt = 1'b1;
				pll_a_arm_nxt = 1'b0;
			end
		end

		if (wr_pll_b_cfg) begin
			pll_b_wait_nxt = pwdata[PLL_CNT_LSB +: PLL_CNT_W];
			pll_b_arm_nxt = 1'b1;
			pll_b_locked_nxt = 1'b0;
		end else if (pll_b_arm_r) begin
			pll_b_wait_nxt = wait_step(pll_b_wait_r, slow_tick);
			if (pll_b_wait_r == '0) begin
				pll_b_locked_nxt = 1'b1;
				pll_b_arm_nxt = 1'b0;
			end
		end

		// Master clock is usable again at the first tick of its new source
		if (wr_mck_cfg) begin
			master_clock_ready_nxt = 1'b0;
		end else if (!master_clock_ready_r && src_tick[mck_src_r]) begin
			master_clock_ready_nxt = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			osc_wait_r <= RST_OSC_CNT;
			main_osc_stable_r <= 1'b0;
			pll_a_wait_r <= RST_PLL_CNT;
			pll_a_arm_r <= 1'b0;
			pll_a_locked_r <= 1'b0;
			pll_b_wait_r <= RST_PLL_CNT;
			pll_b_arm_r <= 1'b0;
			pll_b_locked_r <= 1'b0;
			master_clock_ready_r <= 1'b1;
		end else begin
			osc_wait_r <= osc_wait_nxt;
			main_osc_stable_r <= main_osc_stable_nxt;
			pll_a_wait_r <= pll_a_wait_nxt;
			pll_a_arm_r <= pll_a_arm_nxt;
			pll_a_locked_r <= pll_a_locked_nxt;
			pll_b_wait_r <= pll_b_wait_nxt;
			pll_b_arm_r <= pll_b_arm_nxt;
			pll_b_locked_r <= pll_b_locked_nxt;
			master_clock_ready_r <= master_clock_ready_nxt;
		end
	end

	// Interrupt enables, sticky rise events and the level output
	always_comb begin
		irq_en_nxt = irq_en_r;
		status_q_nxt = status_vec;
		event_nxt = event_r;
		if (wr_irq_en) begin
			irq_en_nxt = irq_en_r | (pwdata[STAT_W-1:0] & STAT_VALID);
		end
		if (wr_irq_dis) begin
			irq_en_nxt = irq_en_r & ~(pwdata[STAT_W-1:0] & STAT_VALID);
		end
		if (wr_events) begin
			event_nxt = event_r & ~pwdata[STAT_W-1:0];
		end
		// A rise in the clearing cycle is kept: set wins
		event_nxt = event_nxt | (status_vec & ~status_q_r & STAT_VALID);
		irq_nxt = |((status_vec | event_r) & irq_en_r);
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			irq_en_r <= RST_IRQ_EN;
			// History starts at the reset status, so release shows no false rise
			status_q_r <= RST_STATUS;
			event_r <= '0;
			irq_r <= 1'b0;
		end else begin
			irq_en_r <= irq_en_nxt;
			status_q_r <= status_q_nxt;
			event_r <= event_nxt;
			irq_r <= irq_nxt;
		end
	end

	for (genvar g = 0; g < NUM_PCK; g++) begin : g_pck
		pcs_prog_clock u_pck (
			.sys_clk(sys_clk),
			.sys_rst(sys_rst),
			.cfg_load(pck_load[g]),
			.cfg_new(pwdata[CFG_W-1:0]),
			.src_tick(src_tick),
			.clk_tick(prog_clk_tick[g]),
			.ready(prog_clock_ready[g])
		);
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irq = irq_r;
endmodule : pcs_top

// ===== pkg/pcs_pkg.sv
// Register map, field layout and reset values of the programmable clock block
package pcs_pkg;
	localparam int ADDR_W = 12;
	localparam int STAT_W = 12;
	localparam int CFG_W = 5;
	localparam int DIV_W = 7;
	localparam int NUM_PCK = 4;

	localparam logic [ADDR_W-1:0] OFS_PCK0 = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_PCK1 = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_PCK2 = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_PCK3 = 12'h00C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_IRQ_DISABLE = 12'h014;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h018;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h01C;
	localparam logic [ADDR_W-1:0] OFS_OSC_CFG = 12'h020;
	localparam logic [ADDR_W-1:0] OFS_PLL_A_CFG = 12'h024;
	localparam logic [ADDR_W-1:0] OFS_PLL_B_CFG = 12'h028;
	localparam logic [ADDR_W-1:0] OFS_MCK_CFG = 12'h02C;
	localparam logic [ADDR_W-1:0] OFS_EVENTS = 12'h030;

	// Shared layout of enable, disable, status, mask and event registers
	localparam int BIT_OSC = 0;
	localparam int BIT_PLL_A = 1;
	localparam int BIT_PLL_B = 2;
	localparam int BIT_MCK = 3;
	localparam int BIT_PCK0 = 8;
	localparam logic [STAT_W-1:0] STAT_VALID = 12'hF0F;

	// Programmable clock register fields
	localparam int SRC_LSB = 0;
	localparam int SRC_W = 2;
	localparam int PRESCALE_SELECT_LSB = 2;
	localparam int PRESCALE_SELECT_W = 3;

	// Own configuration fields
	localparam int OSC_EN_BIT = 0;
	localparam int OSC_CNT_LSB = 8;
	localparam int OSC_CNT_W = 8;
	localparam int PLL_CNT_LSB = 8;
	localparam int PLL_CNT_W = 6;

	// Source select codes
	localparam logic [SRC_W-1:0] SRC_SLOW = 2'h0;
	localparam logic [SRC_W-1:0] SRC_MAIN = 2'h1;
	localparam logic [SRC_W-1:0] SRC_PLL_A = 2'h2;
	localparam logic [SRC_W-1:0] SRC_PLL_B = 2'h3;

	// Reset values
	localparam logic [CFG_W-1:0] RST_PCK_CFG = 5'h00;
	localparam logic [STAT_W-1:0] RST_IRQ_EN = 12'h000;
	localparam logic [STAT_W-1:0] RST_STATUS = 12'hF08;
	localparam logic [OSC_CNT_W-1:0] RST_OSC_CNT = 8'h00;
	localparam logic [PLL_CNT_W-1:0] RST_PLL_CNT = 6'h00;
	localparam logic [SRC_W-1:0] RST_MCK_SRC = SRC_SLOW;

	// Terminal count of the prescaler: 2**code - 1 source ticks
	function automatic logic [DIV_W-1:0] prescale_select_limit(input logic [PRESCALE_SELECT_W-1:0] code);
		logic [DIV_W-1:0] one;
		one = 7'h01;
		prescale_select_limit = (one << code) - one;
	endfunction : prescale_select_limit
endpackage : pcs_pkg

// ===== rtl/pcs_prog_clock.sv
// One programmable clock channel: source select, prescaler, ready flag
module pcs_prog_clock import pcs_pkg::*; (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic cfg_load,
	input wire logic [CFG_W-1:0] cfg_new,
	input wire logic [3:0] src_tick,
	output logic clk_tick,
	output logic ready
);
	logic [CFG_W-1:0] cfg_r, cfg_nxt;
	logic [CFG_W-1:0] pend_cfg_r, pend_cfg_nxt;
	logic pend_r, pend_nxt;
	logic [DIV_W-1:0] div_r, div_nxt;
	logic tick_r, tick_nxt;
	logic ready_r, ready_nxt;

	always_comb begin
		cfg_nxt = cfg_r;
		pend_cfg_nxt = pend_cfg_r;
		pend_nxt = pend_r;
		div_nxt = div_r;
		tick_nxt = 1'b0;
		ready_nxt = ready_r;
		if (cfg_load) begin
			// Old setting keeps running until the new source ticks
			pend_cfg_nxt = cfg_new;
			pend_nxt = 1'b1;
			ready_nxt = 1'b0;
		end else if (pend_r && src_tick[pend_cfg_r[SRC_LSB +: SRC_W]]) begin
			cfg_nxt = pend_cfg_r;
			div_nxt = '0;
			pend_nxt = 1'b0;
			ready_nxt = 1'b1;
		end
		if (!(pend_r && src_tick[pend_cfg_r[SRC_LSB +: SRC_W]]) &&
				src_tick[cfg_r[SRC_LSB +: SRC_W]]) begin
			if (div_r >= prescale_select_limit(cfg_r[PRESCALE_SELECT_LSB +: PRESCALE_SELECT_W])) begin
				div_nxt = '0;
				tick_nxt = 1'b1;
			end else begin
				div_nxt = div_r + 7'h01;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cfg_r <= RST_PCK_CFG;
			pend_cfg_r <= RST_PCK_CFG;
			pend_r <= 1'b0;
			div_r <= '0;
			tick_r <= 1'b0;
			ready_r <= 1'b1;
		end else begin
			cfg_r <= cfg_nxt;
			pend_cfg_r <= pend_cfg_nxt;
			pend_r <= pend_nxt;
			div_r <= div_nxt;
			tick_r <= tick_nxt;
			ready_r <= ready_nxt;
		end
	end

	assign clk_tick = tick_r;
	assign ready = ready_r;
endmodule : pcs_prog_clock

// ===== sim/pcs_top_monitor.sv
// Bus timing, mask and interrupt checks bound to the programmable clock block
module pcs_top_monitor import pcs_pkg::*; (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] src_tick,
	input wire logic [NUM_PCK-1:0] prog_clk_tick,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wr_done;
	logic rd_done;
	logic [STAT_W-1:0] en_mdl_r;
	logic [STAT_W-1:0] en_mdl_nxt;
	assign wr_done = psel && penable && pready && pwrite;
	assign rd_done = psel && penable && pready && !pwrite;
	// Shadow of the enable state, built only from committed writes
	always_comb begin
		en_mdl_nxt = en_mdl_r;
		if (wr_done && paddr == OFS_IRQ_ENABLE) begin
			en_mdl_nxt = en_mdl_r | (pwdata[STAT_W-1:0] & STAT_VALID);
		end else if (wr_done && paddr == OFS_IRQ_DISABLE) begin
			en_mdl_nxt = en_mdl_r & ~pwdata[STAT_W-1:0];
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			en_mdl_r <= RST_IRQ_EN;
		end else begin
			en_mdl_r <= en_mdl_nxt;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	chk_wait_state: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("ready not in second access cycle");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_err_unmapped: assert property (pready && paddr > OFS_EVENTS |-> pslverr)
		else $error("unmapped access not refused");
	chk_irq_masked: assert property (
		en_mdl_r == '0 && $past(en_mdl_r) == '0 |-> !irq)
		else $error("interrupt with nothing enabled");
	chk_mask_read: assert property (
		rd_done && paddr == OFS_IRQ_MASK |-> prdata == {20'h0_0000, STAT_VALID & ~en_mdl_r})
		else $error("mask read wrong");
	chk_wo_zero: assert property (
		rd_done && (paddr == OFS_IRQ_ENABLE || paddr == OFS_IRQ_DISABLE) |-> prdata == '0)
		else $error("write-only register read nonzero");
	chk_status_layout: assert property (
		rd_done && paddr == OFS_STATUS |-> (prdata & ~{20'h0_0000, STAT_VALID}) == '0)
		else $error("status bit outside layout");
	chk_tick_source: assert property (
		$past(src_tick) == 4'h0 && $past(src_tick, 2) == 4'h0 |-> prog_clk_tick == 4'h0)
		else $error("output tick without source tick");
endmodule : pcs_top_monitor

bind pcs_top pcs_top_monitor u_mon (.sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .src_tick(src_tick), .prog_clk_tick(prog_clk_tick),
	.irq(irq));

// ===== sim/tb_pcs_top.sv
// Self-checking bench for the programmable clock and clock status block
module tb_pcs_top import pcs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [ADDR_W-1:0] paddr = '0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] src_tick = 4'h0;
	logic [NUM_PCK-1:0] prog_clk_tick;
	logic irq;
	logic cnt_en = 1'b0;
	logic cnt_clr = 1'b0;
	logic [31:0] pulse_cnt [NUM_PCK];
	int n_errors = 0;
	int check_count = 0;
	pcs_top DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .src_tick(src_tick),
		.prog_clk_tick(prog_clk_tick), .irq(irq));
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		for (int i = 0; i < NUM_PCK; i++) begin
			if (cnt_clr) begin
				pulse_cnt[i] <= 32'h0000_0000;
			end else if (cnt_en) begin
				pulse_cnt[i] <= pulse_cnt[i] + {31'h0, prog_clk_tick[i]};
			end
		end
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int k;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) cmp(32'h0000_0000, 32'h0000_0001);
	endtask : apb
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(a, 1'b1, d, r, e);
	endtask : wr
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(a, 1'b0, 32'h0000_0000, r, e);
		cmp(r & m, exp);
	endtask : rd_chk
	task automatic ticks(input logic [3:0] m, input int n);
		repeat (n) begin
			@(posedge sys_clk);
			src_tick <= m;
			@(posedge sys_clk);
			src_tick <= 4'h0;
		end
	endtask : ticks
	task automatic t_reset();
		rd_chk(OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0F08);
		rd_chk(OFS_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0F0F);
		rd_chk(OFS_IRQ_ENABLE, 32'hFFFF_FFFF, 32'h0000_0000);
		rd_chk(OFS_EVENTS, 32'hFFFF_FFFF, 32'h0000_0000);
		for (int i = 0; i < NUM_PCK; i++) rd_chk(OFS_PCK0 + 12'(4 * i), 32'h1F, 32'h0);
	endtask : t_reset
	// Source k ticks every k+1 cycles, so each channel sees a different rate
	task automatic t_prog_clk(input bit hi);
		logic [2:0] c [NUM_PCK];
		for (int i = 0; i < NUM_PCK; i++) begin
			c[i] = hi ? 3'(6 - i) : 3'(3 - i);
			wr(OFS_PCK0 + 12'(4 * i), {27'h0, c[i], 2'(i)});
			rd_chk(OFS_PCK0 + 12'(4 * i), 32'h1F, {27'h0, c[i], 2'(i)});
		end
		rd_chk(OFS_STATUS, 32'h0000_0F00, 32'h0000_0000);
		ticks(4'hF, 2);
		repeat (4) @(posedge sys_clk);
		rd_chk(OFS_STATUS, 32'h0000_0F00, 32'h0000_0F00);
		cnt_clr <= 1'b1;
		@(posedge sys_clk);
		cnt_clr <= 1'b0;
		for (int n = 0; n < 192; n++) begin
			@(posedge sys_clk);
			cnt_en <= 1'b1;
			src_tick <= {n % 4 == 0, n % 3 == 0, n % 2 == 0, 1'b1};
		end
		@(posedge sys_clk);
		src_tick <= 4'h0;
		repeat (4) @(posedge sys_clk);
		cnt_en <= 1'b0;
		@(posedge sys_clk);
		for (int i = 0; i < NUM_PCK; i++) cmp(pulse_cnt[i], 32'(192 / (i + 1)) >> c[i]);
	endtask : t_prog_clk
	task automatic t_irq();
		wr(OFS_IRQ_ENABLE, 32'h0000_0008);
		rd_chk(OFS_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0F07);
		repeat (2) @(posedge sys_clk);
		cmp({31'h0, irq}, 32'h1);
		wr(OFS_IRQ_DISABLE, 32'h0000_0008);
		wr(OFS_IRQ_ENABLE, 32'h0000_0000);
		rd_chk(OFS_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0F0F);
		repeat (2) @(posedge sys_clk);
		cmp({31'h0, irq}, 32'h0);
		wr(OFS_IRQ_ENABLE, 32'h0000_0F0F);
		wr(OFS_IRQ_DISABLE, 32'h0000_0000);
		rd_chk(OFS_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
		wr(OFS_IRQ_DISABLE, 32'h0000_0F0F);
	endtask : t_irq
	task automatic t_timers();
		logic [31:0] r;
		logic e;
		wr(OFS_IRQ_ENABLE, 32'h0000_0001);
		wr(OFS_OSC_CFG, 32'h0000_0301);
		rd_chk(OFS_STATUS, 32'h0000_0001, 32'h0000_0000);
		ticks(4'h1, 2);
		repeat (3) @(posedge sys_clk);
		rd_chk(OFS_STATUS, 32'h0000_0001, 32'h0000_0000);
		ticks(4'h1, 1);
		repeat (3) @(posedge sys_clk);
		rd_chk(OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
		cmp({31'h0, irq}, 32'h1);
		wr(OFS_IRQ_DISABLE, 32'h0000_0001);
		wr(OFS_OSC_CFG, 32'h0000_0000);
		rd_chk(OFS_STATUS, 32'h0000_0001, 32'h0000_0000);
		wr(OFS_PLL_A_CFG, 32'h0000_0200);
		wr(OFS_PLL_B_CFG, 32'h0000_0400);
		rd_chk(OFS_STATUS, 32'h0000_0006, 32'h0000_0000);
		ticks(4'h1, 1);
		repeat (3) @(posedge sys_clk);
		rd_chk(OFS_STATUS, 32'h0000_0006, 32'h0000_0000);
		ticks(4'h1, 2);
		repeat (3) @(posedge sys_clk);
		rd_chk(OFS_STATUS, 32'h0000_0006, 32'h0000_0002);
		ticks(4'h1, 2);
		repeat (3) @(posedge sys_clk);
		rd_chk(OFS_STATUS, 32'h0000_0006, 32'h0000_0006);
		wr(OFS_MCK_CFG, 32'h0000_0001);
		rd_chk(OFS_STATUS, 32'h0000_0008, 32'h0000_0000);
		ticks(4'h2, 1);
		repeat (3) @(posedge sys_clk);
		rd_chk(OFS_STATUS, 32'h0000_0008, 32'h0000_0008);
		rd_chk(OFS_EVENTS, 32'hFFFF_FFFF, 32'h0000_0F0F);
		wr(OFS_EVENTS, 32'h0000_0F0F);
		rd_chk(OFS_EVENTS, 32'hFFFF_FFFF, 32'h0000_0000);
		apb(12'h040, 1'b0, 32'h0000_0000, r, e);
		cmp({r[30:0], e}, 32'h0000_0001);
	endtask : t_timers
	task automatic results();
		$display("errors=%0d checks=%0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results
	initial begin
		#400_000;
		n_errors++;
		results();
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_prog_clk(1'b0);
		t_prog_clk(1'b1);
		t_irq();
		t_timers();
		results();
	end
endmodule : tb_pcs_top
